// file: hw/uirq_pkg.sv
// package: register map, field layout and reset values of the serial channel register block
package uirq_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BAUD_DIV_HIGH = 8'h08;
    localparam logic [7:0] ADDR_BAUD_DIV_LOW = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_VECTOR = 8'h10;
    localparam logic [7:0] ADDR_INPUT_PIN_STATE = 8'h14;
    localparam logic [7:0] ADDR_INPUT_CHANGE = 8'h18;
    localparam logic [7:0] ADDR_OUTPUT_BIT_SET = 8'h1C;
    localparam logic [7:0] ADDR_OUTPUT_BIT_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_AUX_CONTROL = 8'h24;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h28;
    localparam logic [7:0] ADDR_BREAK_CLEAR = 8'h2C;
    // field positions
    localparam int BIT_COS = 7;
    localparam int BIT_BREAK = 2;
    localparam int BIT_FIFO_FULL = 1;
    localparam int BIT_TX_READY = 0;
    localparam int BIT_RTS = 0;
    localparam int BIT_CTS = 0;
    localparam int BIT_CHG_COS = 4;
    localparam int BIT_IEC = 0;
    localparam int BIT_RF_SEL = 6;
    localparam int BIT_LOOPBACK = 0;
    // writable masks, reserved bits read zero
    localparam logic [7:0] IRQ_ENABLE_MASK = 8'h87;
    // reset values
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] IRQ_VECTOR_RST = 8'h0F;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0002;
    localparam logic [15:0] BAUD_DIV_MIN = 16'h0002;

    // line-side status from the receiver and transmitter
    typedef struct packed {
        logic tx_ready;
        logic rx_ready;
        logic fifo_full;
        logic break_active;
    } uirq_line_t;
endpackage

// file: hw/uirq_regs.sv
// module: interrupt, baud divider, vector and modem port registers of one serial channel
`timescale 1ns/10ps

module uirq_regs
    import uirq_pkg::*;
#(
    parameter int CHANNEL_INDEX = 0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line-side status
    input wire uirq_line_t line_status,
    // modem pins
    input wire logic cts_n_pin,
    output logic rts_n_pin,
    // to the channel core
    output logic irq_out,
    output logic [15:0] baud_preload,
    output logic loopback_en
);

    localparam bit HAS_MODEM = (CHANNEL_INDEX != 2);

    if (CHANNEL_INDEX < 0) begin : g_bad_index
        $error("channel index must not be negative");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] irq_enable_reg, irq_enable_next;
    logic [7:0] baud_div_high_reg, baud_div_high_next;
    logic [7:0] baud_div_low_reg, baud_div_low_next;
    logic [7:0] irq_vector_reg, irq_vector_next;
    logic rts_reg, rts_next;
    logic iec_reg, iec_next;
    logic rf_sel_reg, rf_sel_next;
    logic loop_reg, loop_next;
    logic break_flag_reg, break_flag_next;
    logic cos_flag_reg, cos_flag_next;
    logic [2:0] cts_sync_reg, cts_sync_next;
    logic cts_level_reg, cts_level_next;
    logic brk_prev_reg, brk_prev_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;

    logic acc, wr, rd;
    logic [7:0] status;
    logic [7:0] chg_val;
    logic [7:0] rdval;
    logic mapped;

    // access phase, answered one cycle after penable rises
    assign acc = psel && penable && !pready_reg;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
        return a == ref_addr;
    endfunction

    // ----------------------------------------------------------------
    // status composition
    // ----------------------------------------------------------------
    always_comb begin
        status = 8'h00;
        status[BIT_COS] = cos_flag_reg && iec_reg;
        status[BIT_BREAK] = break_flag_reg;
        status[BIT_FIFO_FULL] = rf_sel_reg ? line_status.fifo_full : line_status.rx_ready;
        status[BIT_TX_READY] = line_status.tx_ready;
        chg_val = 8'h00;
        chg_val[BIT_CHG_COS] = cos_flag_reg;
        chg_val[BIT_CTS] = cts_level_reg;
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rdval = 8'h00;
        mapped = 1'b1;
        if (hit(paddr, ADDR_IRQ_ENABLE)) begin
            rdval = irq_enable_reg;
        end else if (hit(paddr, ADDR_IRQ_STATUS)) begin
            rdval = status;
        end else if (hit(paddr, ADDR_BAUD_DIV_HIGH) || hit(paddr, ADDR_BAUD_DIV_LOW)) begin
            rdval = 8'h00;
        end else if (hit(paddr, ADDR_IRQ_VECTOR)) begin
            rdval = irq_vector_reg;
        end else if (hit(paddr, ADDR_INPUT_PIN_STATE)) begin
            rdval = {7'h00, cts_level_reg};
        end else if (hit(paddr, ADDR_INPUT_CHANGE)) begin
            rdval = chg_val;
        end else if (hit(paddr, ADDR_OUTPUT_BIT_SET) || hit(paddr, ADDR_OUTPUT_BIT_CLEAR)) begin
            rdval = 8'h00;
        end else if (hit(paddr, ADDR_AUX_CONTROL)) begin
            rdval = {7'h00, iec_reg};
        end else if (hit(paddr, ADDR_MODE_CTRL)) begin
            rdval = 8'h00;
            rdval[BIT_RF_SEL] = rf_sel_reg;
            rdval[BIT_LOOPBACK] = loop_reg;
        end else if (hit(paddr, ADDR_BREAK_CLEAR)) begin
            rdval = 8'h00;
        end else begin
            mapped = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        irq_enable_next = irq_enable_reg;
        baud_div_high_next = baud_div_high_reg;
        baud_div_low_next = baud_div_low_reg;
        irq_vector_next = irq_vector_reg;
        rts_next = rts_reg;
        iec_next = iec_reg;
        rf_sel_next = rf_sel_reg;
        loop_next = loop_reg;
        break_flag_next = break_flag_reg;
        cos_flag_next = cos_flag_reg;
        cts_sync_next = {cts_sync_reg[1:0], ~cts_n_pin};
        cts_level_next = cts_level_reg;
        brk_prev_next = line_status.break_active;
        prdata_next = 32'h0000_0000;
        pready_next = acc;
        pslverr_next = acc && !mapped;

        if (rd) begin
            prdata_next = {24'h00_0000, rdval};
            if (hit(paddr, ADDR_INPUT_CHANGE)) begin
                cos_flag_next = 1'b0;
            end
        end
        if (wr) begin
            if (hit(paddr, ADDR_IRQ_ENABLE)) begin
                irq_enable_next = pwdata[7:0] & IRQ_ENABLE_MASK;
            end else if (hit(paddr, ADDR_BAUD_DIV_HIGH)) begin
                baud_div_high_next = pwdata[7:0];
            end else if (hit(paddr, ADDR_BAUD_DIV_LOW)) begin
                baud_div_low_next = pwdata[7:0];
            end else if (hit(paddr, ADDR_IRQ_VECTOR)) begin
                irq_vector_next = pwdata[7:0];
            end else if (hit(paddr, ADDR_OUTPUT_BIT_SET)) begin
                if (pwdata[BIT_RTS]) begin
                    rts_next = HAS_MODEM;
                end
            end else if (hit(paddr, ADDR_OUTPUT_BIT_CLEAR)) begin
                if (pwdata[BIT_RTS]) begin
                    rts_next = 1'b0;
                end
            end else if (hit(paddr, ADDR_AUX_CONTROL)) begin
                iec_next = pwdata[BIT_IEC];
            end else if (hit(paddr, ADDR_MODE_CTRL)) begin
                rf_sel_next = pwdata[BIT_RF_SEL];
                loop_next = pwdata[BIT_LOOPBACK];
            end else if (hit(paddr, ADDR_BREAK_CLEAR)) begin
                break_flag_next = 1'b0;
            end
        end

        // set wins over clear
        if (line_status.break_active != brk_prev_reg) begin
            break_flag_next = 1'b1;
        end
        if (HAS_MODEM && (cts_sync_reg[2] == cts_sync_reg[1])
                && (cts_sync_reg[2] != cts_level_reg)) begin
            cts_level_next = cts_sync_reg[2];
            cos_flag_next = 1'b1;
        end
        if (!HAS_MODEM) begin
            cts_level_next = 1'b0;
            cos_flag_next = 1'b0;
        end

        irq_next = |(status & irq_enable_reg);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable_reg <= IRQ_ENABLE_RST;
            baud_div_high_reg <= BAUD_DIV_RST[15:8];
            baud_div_low_reg <= BAUD_DIV_RST[7:0];
            irq_vector_reg <= IRQ_VECTOR_RST;
            rts_reg <= 1'b0;
            iec_reg <= 1'b0;
            rf_sel_reg <= 1'b0;
            loop_reg <= 1'b0;
            break_flag_reg <= 1'b0;
            cos_flag_reg <= 1'b0;
            cts_sync_reg <= 3'h0;
            cts_level_reg <= 1'b0;
            brk_prev_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_enable_reg <= irq_enable_next;
            baud_div_high_reg <= baud_div_high_next;
            baud_div_low_reg <= baud_div_low_next;
            irq_vector_reg <= irq_vector_next;
            rts_reg <= rts_next;
            iec_reg <= iec_next;
            rf_sel_reg <= rf_sel_next;
            loop_reg <= loop_next;
            break_flag_reg <= break_flag_next;
            cos_flag_reg <= cos_flag_next;
            cts_sync_reg <= cts_sync_next;
            cts_level_reg <= cts_level_next;
            brk_prev_reg <= brk_prev_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic rts_pin_reg;
    logic [15:0] preload_reg;
    logic loop_out_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rts_pin_reg <= 1'b1;
            preload_reg <= BAUD_DIV_RST;
            loop_out_reg <= 1'b0;
        end else begin
            rts_pin_reg <= ~rts_next;
            preload_reg <= {baud_div_high_next, baud_div_low_next};
            loop_out_reg <= loop_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_out = irq_reg;
    assign rts_n_pin = rts_pin_reg;
    assign baud_preload = preload_reg;
    assign loopback_en = loop_out_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_irq_from_mask: assert property (
        ##1 irq_out == $past(|(status & irq_enable_reg)))
        else $error("interrupt output disagrees with masked status");
    a_status_read_true: assert property (
        rd && hit(paddr, ADDR_IRQ_STATUS) |=> prdata[7:0] == $past(status))
        else $error("status read not true status");
    a_enable_resv_zero: assert property (
        (irq_enable_reg & ~IRQ_ENABLE_MASK) == 8'h00)
        else $error("reserved enable bits set");
    a_baud_read_zero: assert property (
        rd && (hit(paddr, ADDR_BAUD_DIV_HIGH) || hit(paddr, ADDR_BAUD_DIV_LOW))
        |=> prdata == 32'h0000_0000)
        else $error("divider byte readable");
    a_preload_concat: assert property (
        baud_preload == {baud_div_high_reg, baud_div_low_reg})
        else $error("preload not concatenation of bytes");
    a_rts_pin_inv: assert property (
        rts_n_pin == ~rts_reg)
        else $error("rts pin not inverted from bit");
    sequence s_set_one;
        wr && hit(paddr, ADDR_OUTPUT_BIT_SET) && pwdata[BIT_RTS];
    endsequence
    a_rts_set_write: assert property (
        s_set_one |=> rts_reg == HAS_MODEM)
        else $error("output set write failed");
    a_rts_zero_hold: assert property (
        wr && hit(paddr, ADDR_OUTPUT_BIT_SET) && !pwdata[BIT_RTS] |=> $stable(rts_reg))
        else $error("zero write changed rts");
    a_rts_clear_write: assert property (
        wr && hit(paddr, ADDR_OUTPUT_BIT_CLEAR) && pwdata[BIT_RTS] |=> !rts_reg)
        else $error("output clear write failed");
    a_break_edge_set: assert property (
        line_status.break_active != brk_prev_reg |=> break_flag_reg)
        else $error("break change not flagged");
    a_pin_eq_change: assert property (
        chg_val[BIT_CTS] == cts_level_reg)
        else $error("input port and change register differ");
    a_apb_one_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // ----------------------------------------------------------------
    // register writes and pin behaviour
    // ----------------------------------------------------------------
    a_enable_write: assert property (
        wr && hit(paddr, ADDR_IRQ_ENABLE)
        |=> irq_enable_reg == ($past(pwdata[7:0]) & IRQ_ENABLE_MASK))
        else $error("enable write not stored with reserved bits dropped");
    a_baud_high_write: assert property (
        wr && hit(paddr, ADDR_BAUD_DIV_HIGH) |=> baud_preload[15:8] == $past(pwdata[7:0]))
        else $error("high divider byte not loaded");
    a_baud_low_write: assert property (
        wr && hit(paddr, ADDR_BAUD_DIV_LOW) |=> baud_preload[7:0] == $past(pwdata[7:0]))
        else $error("low divider byte not loaded");
    a_vector_write: assert property (
        wr && hit(paddr, ADDR_IRQ_VECTOR) |=> irq_vector_reg == $past(pwdata[7:0]))
        else $error("vector write not stored");
    a_cts_level_follow: assert property (
        HAS_MODEM && (cts_sync_reg[2] == cts_sync_reg[1])
        |=> cts_level_reg == $past(cts_sync_reg[2]))
        else $error("clear-to-send state lags settled pin");
    a_cos_read_clear: assert property (
        rd && hit(paddr, ADDR_INPUT_CHANGE) && (cts_sync_reg[2] == cts_level_reg)
        |=> !cos_flag_reg)
        else $error("change register read left change flag set");
    a_break_clear_wr: assert property (
        wr && hit(paddr, ADDR_BREAK_CLEAR) && (line_status.break_active == brk_prev_reg)
        |=> !break_flag_reg)
        else $error("break flag not cleared by write");
    a_no_modem_rts: assert property (
        !HAS_MODEM |-> rts_n_pin)
        else $error("request-to-send driven on channel without modem port");
    a_no_modem_cts: assert property (
        !HAS_MODEM |-> !cts_level_reg && !cos_flag_reg)
        else $error("clear-to-send logic active on channel without modem port");
    a_loopback_write: assert property (
        wr && hit(paddr, ADDR_MODE_CTRL) |=> loopback_en == $past(pwdata[BIT_LOOPBACK]))
        else $error("loopback control not loaded");
    a_unmapped_refused: assert property (
        acc && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (
        acc && mapped |=> !pslverr)
        else $error("mapped access flagged as error");

endmodule // uirq_regs

// file: dv/uirq_line_model.sv
// line-side partner: remote serial device driving status levels and clear-to-send
`timescale 1ns/10ps
module uirq_line_model
    import uirq_pkg::*;
(
    // clock
    input wire logic core_clk,
    // bench control
    input wire uirq_line_t status_req,
    input wire logic cts_req,
    // channel pins
    input wire logic rts_n_pin,
    output logic cts_n_pin,
    output uirq_line_t line_status,
    output logic rts_seen
);
    initial begin
        cts_n_pin = 1'h1;
        line_status = '0;
    end
    // levels change just after the edge, like the real receiver
    always @(posedge core_clk) begin
        cts_n_pin <= ~cts_req;
        line_status <= status_req;
    end
    // pin is active low
    assign rts_seen = ~rts_n_pin;
endmodule // uirq_line_model

// file: dv/uirq_regs_test.sv
// testbench: register-side checks of one serial channel over apb
`timescale 1ns/10ps
module uirq_regs_test;
    import uirq_pkg::*;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic irq_out, loopback_en, cts_n_pin, rts_n_pin, cts_req, rts_seen, e;
    logic rts2_n_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] baud_preload;
    uirq_line_t line_status, status_req;
    int fails, n_tests;

    uirq_regs #(.CHANNEL_INDEX(0)) dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_status(line_status),
        .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin), .irq_out(irq_out),
        .baud_preload(baud_preload), .loopback_en(loopback_en)
    );
    uirq_line_model line_u (
        .core_clk(core_clk), .status_req(status_req), .cts_req(cts_req),
        .rts_n_pin(rts_n_pin), .cts_n_pin(cts_n_pin), .line_status(line_status),
        .rts_seen(rts_seen)
    );
    // channel without modem port, shares the bus but answers unread
    uirq_regs #(.CHANNEL_INDEX(2)) dut_nomodem_u (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .line_status(line_status),
        .cts_n_pin(cts_n_pin), .rts_n_pin(rts2_n_pin), .irq_out(),
        .baud_preload(), .loopback_en()
    );

    always #5 core_clk = ~core_clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk("pready", 32'h1, {31'h0, pready});
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(name, exp, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'h0;
        arst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        status_req = '0;
        cts_req = 1'h0;
        fails = 0;
        n_tests = 0;
        idle(20);
        arst_n <= 1'h1;
        @(posedge core_clk);
        chk("rts_n_pin rst", 32'h1, {31'h0, rts_n_pin});
        rd(ADDR_IRQ_ENABLE, "irq_enable rst", 32'h0);
        rd(ADDR_IRQ_VECTOR, "irq_vector rst", 32'h0F);
        rd(ADDR_IRQ_STATUS, "irq_status rst", 32'h0);
        wr(ADDR_IRQ_ENABLE, 32'hFFFFFFFF);
        rd(ADDR_IRQ_ENABLE, "irq_enable rsvd", 32'h87);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        // divider, programmed no lower than two
        wr(ADDR_BAUD_DIV_HIGH, 32'h12);
        wr(ADDR_BAUD_DIV_LOW, 32'h34);
        chk("baud_preload", 32'h1234, {16'h0, baud_preload});
        rd(ADDR_BAUD_DIV_HIGH, "baud_div_high rd", 32'h0);
        rd(ADDR_BAUD_DIV_LOW, "baud_div_low rd", 32'h0);
        wr(ADDR_IRQ_VECTOR, 32'hA5);
        rd(ADDR_IRQ_VECTOR, "irq_vector", 32'hA5);
        // masking: tx ready, then rx ready / fifo full selection
        status_req <= uirq_line_t'(4'h8);
        idle(4);
        chk("irq_out masked", 32'h0, {31'h0, irq_out});
        rd(ADDR_IRQ_STATUS, "irq_status tx_ready", 32'h01);
        wr(ADDR_IRQ_ENABLE, 32'h01);
        idle(3);
        chk("irq_out tx_ready", 32'h1, {31'h0, irq_out});
        status_req <= uirq_line_t'(4'h4);
        idle(4);
        chk("irq_out rx masked", 32'h0, {31'h0, irq_out});
        rd(ADDR_IRQ_STATUS, "irq_status rx_ready", 32'h02);
        wr(ADDR_IRQ_ENABLE, 32'h02);
        idle(3);
        chk("irq_out rx_ready", 32'h1, {31'h0, irq_out});
        wr(ADDR_MODE_CTRL, 32'h40);
        rd(ADDR_IRQ_STATUS, "irq_status fifo_full sel", 32'h0);
        status_req <= uirq_line_t'(4'h2);
        idle(4);
        rd(ADDR_IRQ_STATUS, "irq_status fifo_full", 32'h02);
        // break start and end each raise the flag
        wr(ADDR_MODE_CTRL, 32'h01);
        chk("loopback_en", 32'h1, {31'h0, loopback_en});
        status_req <= uirq_line_t'(4'h1);
        idle(4);
        rd(ADDR_IRQ_STATUS, "irq_status brk start", 32'h04);
        wr(ADDR_IRQ_ENABLE, 32'h04);
        idle(3);
        chk("irq_out brk", 32'h1, {31'h0, irq_out});
        wr(ADDR_BREAK_CLEAR, 32'h01);
        rd(ADDR_IRQ_STATUS, "irq_status brk clr", 32'h0);
        status_req <= uirq_line_t'(4'h0);
        idle(4);
        rd(ADDR_IRQ_STATUS, "irq_status brk end", 32'h04);
        // clear-to-send settles through the synchroniser before it is read
        wr(ADDR_AUX_CONTROL, 32'h01);
        cts_req <= 1'h1;
        idle(8);
        rd(ADDR_IRQ_STATUS, "irq_status cos", 32'h84);
        rd(ADDR_INPUT_PIN_STATE, "input_pin_state on", 32'h01);
        apb(1'h0, ADDR_INPUT_CHANGE, 32'h0);
        chk("input_change", 32'h11, q);
        rd(ADDR_IRQ_STATUS, "irq_status cos clr", 32'h04);
        cts_req <= 1'h0;
        idle(8);
        rd(ADDR_INPUT_PIN_STATE, "input_pin_state off", 32'h0);
        // request-to-send set and clear addresses
        wr(ADDR_OUTPUT_BIT_SET, 32'h0);
        chk("rts zero write", 32'h1, {31'h0, rts_n_pin});
        wr(ADDR_OUTPUT_BIT_SET, 32'h1);
        chk("rts set", 32'h1, {31'h0, rts_seen});
        chk("rts no modem", 32'h1, {31'h0, rts2_n_pin});
        wr(ADDR_OUTPUT_BIT_SET, 32'h0);
        chk("rts held", 32'h0, {31'h0, rts_n_pin});
        wr(ADDR_OUTPUT_BIT_CLEAR, 32'h1);
        chk("rts clear", 32'h1, {31'h0, rts_n_pin});
        // unmapped address refused
        apb(1'h0, 8'h30, 32'h0);
        chk("pslverr unmapped", 32'h1, {31'h0, e});
        chk("prdata unmapped", 32'h0, q);
        // mid-run reset clears sticky flags and restores the vector
        arst_n <= 1'h0;
        idle(2);
        arst_n <= 1'h1;
        @(posedge core_clk);
        rd(ADDR_IRQ_STATUS, "irq_status mid rst", 32'h0);
        rd(ADDR_IRQ_VECTOR, "irq_vector mid rst", 32'h0F);
        tally_and_finish();
    end
endmodule // uirq_regs_test
